// [core/tmf_mode_ctrl.sv]
// tmf_mode_ctrl: mode, function and output master control for a five-channel 16-bit timer unit.
// assumes the counters and compare logic live next door; this block steers them and gates the pins.
// assumes quad inputs are asynchronous pins; every other input is on clk.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module tmf_mode_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        standby,
  // register port
  input  wire logic [2:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData,
  // quadrature pins
  input  wire logic        quadInputA,
  input  wire logic        quadInputB,
  // channel 2 counter steering
  input  wire logic        chan2NormalTick,
  input  wire logic        chan2Overflow,
  input  wire logic        chan2Underflow,
  output logic             chan2CountEn,
  output logic             chan2CountDown,
  output logic             chan2OverflowFlagSet,
  // per-channel compare matches and normal pin A drive
  input  wire logic [4:0]  cmpMatchA,
  input  wire logic [4:0]  cmpMatchB,
  input  wire logic [4:0]  normPinA,
  input  wire logic [4:0]  normPinAOe,
  output logic      [4:0]  pinAOut,
  output logic      [4:0]  pinAOe,
  // channels 3 and 4 pin B normal drive, index 0 = ch3, 1 = ch4
  input  wire logic [1:0]  normPinB,
  input  wire logic [1:0]  normPinBOe,
  output logic      [1:0]  pinBOut,
  output logic      [1:0]  pinBOe,
  // buffer selects {b4, a4, b3, a3}
  output logic      [3:0]  bufferSel,
  output logic             irq
);

  logic       initAll;
  logic [7:0] modeSelect_r;
  logic [7:0] funcControl_r;
  logic [7:0] outMasterEnable_r;
  logic [7:0] irqStatus_r;
  logic [7:0] irqMask_r;
  logic [7:0] rdData_nxt;

  logic       phaseCountSelect;
  logic       overflowFlagDirection;
  logic [4:0] pwmSelect;

  // reset and standby both bring the control registers back to their initial values
  assign initAll = rst | standby;

  assign phaseCountSelect      = modeSelect_r[tmf_pkg::POS_PHASE_COUNT_SELECT];
  assign overflowFlagDirection = modeSelect_r[tmf_pkg::POS_OVERFLOW_FLAG_DIR];
  assign pwmSelect             = modeSelect_r[tmf_pkg::POS_PWM_SELECT_LSB +: tmf_pkg::NUM_CH];

  // mode_select_reg
  always_ff @(posedge clk) begin
    if (initAll) begin
      modeSelect_r <= tmf_pkg::RST_MODE;
    end else if (regWr && regAddr == tmf_pkg::OFS_MODE) begin
      modeSelect_r <= regWrData | tmf_pkg::RO1_MODE;
    end
  end

  // function_control_reg; bits 5,4 are kept as written, software keeps them at zero
  always_ff @(posedge clk) begin
    if (initAll) begin
      funcControl_r <= tmf_pkg::RST_FUNC;
    end else if (regWr && regAddr == tmf_pkg::OFS_FUNC) begin
      funcControl_r <= regWrData | tmf_pkg::RO1_FUNC;
    end
  end

  // output_master_enable_reg
  always_ff @(posedge clk) begin
    if (initAll) begin
      outMasterEnable_r <= tmf_pkg::RST_OUT_EN;
    end else if (regWr && regAddr == tmf_pkg::OFS_OUT_EN) begin
      outMasterEnable_r <= regWrData | tmf_pkg::RO1_OUT_EN;
    end
  end

  // quad pins: three-stage synchroniser, a change counts once stages two and three agree
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  logic       stableA_r;
  logic       stableB_r;
  logic       newA;
  logic       newB;
  logic       edgeA;
  logic       edgeB;

  always_ff @(posedge clk) begin
    if (rst) begin
      syncA_r <= 3'h0;
      syncB_r <= 3'h0;
    end else begin
      syncA_r <= {syncA_r[1:0], quadInputA};
      syncB_r <= {syncB_r[1:0], quadInputB};
    end
  end

  assign newA = (syncA_r[1] == syncA_r[2]) ? syncA_r[2] : stableA_r;
  assign newB = (syncB_r[1] == syncB_r[2]) ? syncB_r[2] : stableB_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      stableA_r <= 1'b0;
      stableB_r <= 1'b0;
    end else begin
      stableA_r <= newA;
      stableB_r <= newB;
    end
  end

  assign edgeA = newA ^ stableA_r;
  assign edgeB = newB ^ stableB_r;

  // both edges of both inputs count; direction comes from which input leads
  logic quadStep;
  logic quadDown;
  logic phaseError;

  always_comb begin
    quadStep   = 1'b0;
    quadDown   = 1'b0;
    phaseError = 1'b0;
    if (edgeA && edgeB) begin
      // simultaneous change carries no direction, so it is dropped, and reported when phase counting is selected
      phaseError = phaseCountSelect;
    end else if (edgeA) begin
      quadStep = 1'b1;
      // A rising with B low, or A falling with B high, counts down
      quadDown = newA ^ stableB_r;
    end else if (edgeB) begin
      quadStep = 1'b1;
      // B rising with A high, or B falling with A low, counts down
      quadDown = ~(newB ^ stableA_r);
    end
  end

  // channel 2 count steering; clear, compare and capture remain with the counter logic
  always_ff @(posedge clk) begin
    if (rst) begin
      chan2CountEn   <= 1'b0;
      chan2CountDown <= 1'b0;
    end else if (phaseCountSelect) begin
      chan2CountEn   <= quadStep;
      chan2CountDown <= quadDown;
    end else begin
      chan2CountEn   <= chan2NormalTick;
      chan2CountDown <= 1'b0;
    end
  end

  // overflow flag set condition applies in every mode
  logic ovfFlagEvent;

  assign ovfFlagEvent = chan2Overflow | (chan2Underflow & ~overflowFlagDirection);

  always_ff @(posedge clk) begin
    if (rst) begin
      chan2OverflowFlagSet <= 1'b0;
    end else begin
      chan2OverflowFlagSet <= ovfFlagEvent;
    end
  end

  // pin A per channel: PWM set/reset latch or the normal compare output
  // each channel keeps its own flip-flop so no vector has several writing processes
  wire logic [4:0] pwmLevel;

  genvar ch;
  generate
    for (ch = 0; ch < tmf_pkg::NUM_CH; ch++) begin : g_chan
      logic level_r;
      always_ff @(posedge clk) begin
        if (rst) begin
          level_r <= 1'b0;
        end else if (cmpMatchB[ch]) begin
          // match B wins when both hit together so a zero-width pulse stays low
          level_r <= 1'b0;
        end else if (cmpMatchA[ch]) begin
          level_r <= 1'b1;
        end
      end
      assign pwmLevel[ch] = level_r;
    end
  endgenerate

  logic [4:0] pinAOut_nxt;
  logic [4:0] pinAOe_nxt;
  logic [4:0] pinAMaster;

  // only channels 3 and 4 have a master enable on pin A
  assign pinAMaster = {outMasterEnable_r[tmf_pkg::POS_OUT_ENABLE_A_CH4],
                       outMasterEnable_r[tmf_pkg::POS_OUT_ENABLE_A_CH3], 3'h7};

  always_comb begin
    pinAOut_nxt = 5'h00;
    pinAOe_nxt  = 5'h00;
    for (int i = 0; i < tmf_pkg::NUM_CH; i++) begin
      if (pwmSelect[i]) begin
        pinAOut_nxt[i] = pwmLevel[i];
        pinAOe_nxt[i]  = 1'b1;
      end else begin
        pinAOut_nxt[i] = normPinA[i];
        pinAOe_nxt[i]  = normPinAOe[i];
      end
      // master enable off overrides mode, I/O control and buffer settings
      if (!pinAMaster[i]) begin
        pinAOe_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinAOut <= 5'h00;
      pinAOe  <= 5'h00;
    end else begin
      pinAOut <= pinAOut_nxt;
      pinAOe  <= pinAOe_nxt;
    end
  end

  // pin B of channels 3 and 4 gated by their master enables
  always_ff @(posedge clk) begin
    if (rst) begin
      pinBOut <= 2'h0;
      pinBOe  <= 2'h0;
    end else begin
      pinBOut   <= normPinB;
      pinBOe[0] <= normPinBOe[0] & outMasterEnable_r[tmf_pkg::POS_OUT_ENABLE_B_CH3];
      pinBOe[1] <= normPinBOe[1] & outMasterEnable_r[tmf_pkg::POS_OUT_ENABLE_B_CH4];
    end
  end

  // buffer selects pass through one flip-flop to the compare/buffer transfer logic
  always_ff @(posedge clk) begin
    if (rst) begin
      bufferSel <= 4'h0;
    end else begin
      bufferSel <= funcControl_r[tmf_pkg::POS_BUFFER_SEL_LSB +: 4];
    end
  end

  // interrupt status: sticky, write one to clear, a new event beats the clear
  logic [7:0] irqEvents;
  logic [7:0] irqClear;

  always_comb begin
    irqEvents = 8'h00;
    irqEvents[tmf_pkg::POS_IRQ_OVERFLOW_FLAG] = ovfFlagEvent;
    irqEvents[tmf_pkg::POS_IRQ_PHASE_ERROR]   = phaseError;
  end

  assign irqClear = (regWr && regAddr == tmf_pkg::OFS_IRQ_STAT) ? regWrData : 8'h00;

  always_ff @(posedge clk) begin
    if (initAll) begin
      irqStatus_r <= tmf_pkg::RST_IRQ_STAT;
    end else begin
      irqStatus_r <= ((irqStatus_r & ~irqClear) | irqEvents) & tmf_pkg::IRQ_USED_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (initAll) begin
      irqMask_r <= tmf_pkg::RST_IRQ_MASK;
    end else if (regWr && regAddr == tmf_pkg::OFS_IRQ_MASK) begin
      irqMask_r <= regWrData & tmf_pkg::IRQ_USED_MASK;
    end
  end

  // irq lags status by one cycle so that it leaves a flip-flop
  always_ff @(posedge clk) begin
    if (initAll) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_r & irqMask_r);
    end
  end

  // read path: data stand in the cycle after the strobe, zero otherwise
  always_comb begin
    case (regAddr)
      tmf_pkg::OFS_MODE:     rdData_nxt = modeSelect_r;
      tmf_pkg::OFS_FUNC:     rdData_nxt = funcControl_r;
      tmf_pkg::OFS_OUT_EN:   rdData_nxt = outMasterEnable_r;
      tmf_pkg::OFS_IRQ_STAT: rdData_nxt = irqStatus_r;
      tmf_pkg::OFS_IRQ_MASK: rdData_nxt = irqMask_r;
      default:               rdData_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      regRdData <= rdData_nxt;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule

// [core/tmf_pkg.sv]
// tmf_pkg: register map, field positions and reset values of the timer mode/function control block.
// assumes a byte-wide register port with a 3-bit address inside the timer unit.
package tmf_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_CH = 5;

  // register offsets
  localparam logic [2:0] OFS_MODE     = 3'h0;
  localparam logic [2:0] OFS_FUNC     = 3'h1;
  localparam logic [2:0] OFS_OUT_EN   = 3'h2;
  localparam logic [2:0] OFS_IRQ_STAT = 3'h3;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h4;

  // reset values
  localparam logic [7:0] RST_MODE     = 8'h80;
  localparam logic [7:0] RST_FUNC     = 8'hc0;
  localparam logic [7:0] RST_OUT_EN   = 8'hff;
  localparam logic [7:0] RST_IRQ_STAT = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;

  // read-only-one masks
  localparam logic [7:0] RO1_MODE   = 8'h80;
  localparam logic [7:0] RO1_FUNC   = 8'hc0;
  localparam logic [7:0] RO1_OUT_EN = 8'hc0;

  // mode_select_reg fields
  localparam int unsigned POS_PHASE_COUNT_SELECT  = 6;
  localparam int unsigned POS_OVERFLOW_FLAG_DIR   = 5;
  localparam int unsigned POS_PWM_SELECT_LSB      = 0;

  // function_control_reg fields
  localparam int unsigned POS_BUFFER_SEL_LSB      = 0;
  localparam int unsigned POS_FUNC_SPARE_LSB      = 4;

  // output_master_enable_reg fields
  localparam int unsigned POS_OUT_ENABLE_A_CH3    = 0;
  localparam int unsigned POS_OUT_ENABLE_A_CH4    = 1;
  localparam int unsigned POS_OUT_ENABLE_B_CH4    = 2;
  localparam int unsigned POS_OUT_ENABLE_B_CH3    = 3;

  // interrupt status/mask fields
  localparam int unsigned POS_IRQ_OVERFLOW_FLAG   = 0;
  localparam int unsigned POS_IRQ_PHASE_ERROR     = 1;
  localparam logic [7:0]  IRQ_USED_MASK           = 8'h03;

endpackage

// [dv/tmf_quad_src.sv]
// tmf_quad_src: quadrature encoder standing in for the pins of channel 2.
// assumes one step request at a time, spaced well apart by the bench.
`timescale 1ns/1ps
module tmf_quad_src (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic stepReq,
  input  wire logic stepDown,
  input  wire logic stepTwo,
  output logic      quadA,
  output logic      quadB
);
  logic [1:0] phase_r;
  always_ff @(posedge clk) begin
    if (rst)
      phase_r <= 2'h0;
    else if (stepReq)
      // a double step moves both pins at once, which carries no direction
      phase_r <= stepTwo ? phase_r + 2'h2 : (stepDown ? phase_r - 2'h1 : phase_r + 2'h1);
  end
  // gray order 00,01,11,10 counts up; only one pin moves per single step
  assign quadA = phase_r[1];
  assign quadB = phase_r[1] ^ phase_r[0];
endmodule

// [dv/tmf_mode_ctrl_chk.sv]
// tmf_mode_ctrl_chk: port-level assertions for the mode/function control block.
// assumes it is bound to tmf_mode_ctrl and sees its ports only.
`timescale 1ns/1ps
module tmf_mode_ctrl_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       standby,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  input wire logic       chan2Overflow,
  input wire logic       chan2Underflow,
  input wire logic       chan2CountDown,
  input wire logic       chan2OverflowFlagSet,
  input wire logic [4:0] cmpMatchA,
  input wire logic [4:0] cmpMatchB,
  input wire logic [4:0] pinAOut,
  input wire logic [4:0] pinAOe,
  input wire logic [1:0] pinBOe
);
  logic [7:0] modeR;
  logic [7:0] oeR;
  // shadows of the registers the pin logic depends on
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      modeR <= 8'h80;
      oeR   <= 8'hff;
    end else if (regWr && regAddr == 3'h0) begin
      modeR <= regWrData | 8'h80;
    end else if (regWr && regAddr == 3'h2) begin
      oeR <= regWrData | 8'hc0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_mode_read: assert property (regRd && regAddr == 3'h0 |=> regRdData == modeR)
    else $error("mode read wrong");
  chk_func_ro: assert property (regRd && regAddr == 3'h1 |=> regRdData[7:6] == 2'h3)
    else $error("function top bits not one");
  chk_oe_read: assert property (regRd && regAddr == 3'h2 |=> regRdData == oeR)
    else $error("output enable read wrong");
  chk_pwm_set: assert property (modeR[0] && cmpMatchA[0] && !cmpMatchB[0] |-> ##2 pinAOut[0])
    else $error("pwm pin did not rise");
  chk_pwm_clr: assert property (modeR[4] && cmpMatchB[4] |-> ##2 !pinAOut[4])
    else $error("pwm pin did not fall");
  chk_pwm_drive: assert property (modeR[2] |=> pinAOe[2])
    else $error("pwm pin not driven");
  chk_gate_b3: assert property (!oeR[3] |=> !pinBOe[0])
    else $error("gated pin driven");
  chk_gate_a3: assert property (!oeR[0] |=> !pinAOe[3])
    else $error("gated pin driven");
  chk_ovf_flag: assert property (chan2Overflow |=> chan2OverflowFlagSet)
    else $error("overflow flag missed");
  chk_unf_dir: assert property (chan2Underflow && !chan2Overflow |=> chan2OverflowFlagSet == !modeR[5])
    else $error("underflow flag wrong");
  chk_dir_idle: assert property (!modeR[6] |=> !chan2CountDown)
    else $error("down count outside phase mode");
endmodule

bind tmf_mode_ctrl tmf_mode_ctrl_chk u_tmf_mode_ctrl_chk (
  .clk(clk), .rst(rst), .standby(standby), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .chan2Overflow(chan2Overflow),
  .chan2Underflow(chan2Underflow), .chan2CountDown(chan2CountDown),
  .chan2OverflowFlagSet(chan2OverflowFlagSet), .cmpMatchA(cmpMatchA), .cmpMatchB(cmpMatchB),
  .pinAOut(pinAOut), .pinAOe(pinAOe), .pinBOe(pinBOe)
);

// [dv/test_tmf_mode_ctrl.sv]
// test_tmf_mode_ctrl: self-checking bench for the mode/function control block.
// assumes the quad encoder model on the pins and the bound checker.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %h got %h", n, e, g); end end
module test_tmf_mode_ctrl;
  logic       clk = 1'b0, rst = 1'b1, standby = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic       tick = 1'b0, ovf = 1'b0, unf = 1'b0, stepReq = 1'b0, stepDown = 1'b0, stepTwo = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWrData = 8'h00, regRdData;
  logic [4:0] matchA = 5'h00, matchB = 5'h00, normAOe = 5'h1f, normA = 5'h15, pinAOut, pinAOe;
  logic [1:0] normB = 2'h2, pinBOut, pinBOe;
  logic [3:0] bufferSel;
  logic       quadA, quadB, countEn, countDown, flagSet, irq;
  int         error_cnt = 0, num_checks = 0, upCnt = 0, dnCnt = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (countEn && countDown)
      dnCnt++;
    else if (countEn)
      upCnt++;
  end
  tmf_quad_src u_tmf_quad_src (.clk(clk), .rst(rst), .stepReq(stepReq), .stepDown(stepDown),
    .stepTwo(stepTwo), .quadA(quadA), .quadB(quadB));
  tmf_mode_ctrl u_tmf_mode_ctrl (.clk(clk), .rst(rst), .standby(standby), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .quadInputA(quadA), .quadInputB(quadB), .chan2NormalTick(tick), .chan2Overflow(ovf),
    .chan2Underflow(unf), .chan2CountEn(countEn), .chan2CountDown(countDown),
    .chan2OverflowFlagSet(flagSet), .cmpMatchA(matchA), .cmpMatchB(matchB), .normPinA(normA),
    .normPinAOe(normAOe), .pinAOut(pinAOut), .pinAOe(pinAOe), .normPinB(normB), .normPinBOe(2'h3),
    .pinBOut(pinBOut), .pinBOe(pinBOe), .bufferSel(bufferSel), .irq(irq));
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdChk(input logic [2:0] a, input logic [7:0] e, input string n);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    `CHK(n, e, regRdData)
    @(posedge clk);
  endtask
  task automatic step(input logic d);
    stepReq <= 1'b1;
    stepDown <= d;
    @(posedge clk);
    stepReq <= 1'b0;
    repeat (9) @(posedge clk);
  endtask
  // overflow/underflow pulse, flag request expected one cycle later
  task automatic evt(input logic o, input logic u, input logic e);
    ovf <= o;
    unf <= u;
    @(posedge clk);
    ovf <= 1'b0;
    unf <= 1'b0;
    @(negedge clk);
    `CHK("flagSet", e, flagSet)
    @(posedge clk);
  endtask
  // irq is a registered level, so allow a few cycles but no more
  task automatic waitIrq(input logic e);
    int i;
    @(negedge clk);
    for (i = 0; i < 8 && irq !== e; i++)
      @(negedge clk);
    `CHK("irq", e, irq)
    @(posedge clk);
    if (irq !== e)
      give_verdict();
  endtask
  task automatic t_regs;
    rdChk(3'h0, 8'h80, "mode");
    rdChk(3'h1, 8'hc0, "func");
    rdChk(3'h2, 8'hff, "outEn");
    rdChk(3'h5, 8'h00, "unmapped");
    wr(3'h0, 8'h00);
    rdChk(3'h0, 8'h80, "mode");
    wr(3'h1, 8'h0f);
    rdChk(3'h1, 8'hcf, "func");
    `CHK("bufferSel", 4'hf, bufferSel)
    wr(3'h2, 8'h30);
    rdChk(3'h2, 8'hf0, "outEn");
  endtask
  task automatic t_gate;
    @(negedge clk);
    `CHK("pinBOe", 2'h0, pinBOe)
    `CHK("pinAOe", 5'h07, pinAOe)
    `CHK("pinBOut", 2'h2, pinBOut)
    `CHK("pinAOut", 5'h15, pinAOut)
    @(posedge clk);
    wr(3'h2, 8'h0f);
    @(negedge clk);
    `CHK("pinBOe", 2'h3, pinBOe)
    `CHK("pinAOe", 5'h1f, pinAOe)
    @(posedge clk);
  endtask
  task automatic t_pwm;
    normAOe <= 5'h00;
    wr(3'h0, 8'h9f);
    // channel 2 sees both matches at once, so match B must win there
    matchA <= 5'h1f;
    matchB <= 5'h04;
    @(posedge clk);
    matchA <= 5'h00;
    matchB <= 5'h00;
    repeat (2) @(negedge clk);
    `CHK("pinAOut", 5'h1b, pinAOut)
    `CHK("pinAOe", 5'h1f, pinAOe)
    @(posedge clk);
    matchB <= 5'h1f;
    @(posedge clk);
    matchB <= 5'h00;
    repeat (2) @(negedge clk);
    `CHK("pinAOut", 5'h00, pinAOut)
    @(posedge clk);
    wr(3'h0, 8'h80);
    @(negedge clk);
    `CHK("pinAOe", 5'h00, pinAOe)
    `CHK("pinAOut", 5'h15, pinAOut)
    @(posedge clk);
  endtask
  task automatic t_quad;
    wr(3'h0, 8'hc0);
    tick <= 1'b1;
    upCnt = 0;
    dnCnt = 0;
    repeat (4) step(1'b0);
    repeat (3) step(1'b1);
    `CHK("upCnt", 4, upCnt)
    `CHK("dnCnt", 3, dnCnt)
    // both pins moving together carries no direction: no count, phase error status
    stepTwo <= 1'b1;
    step(1'b0);
    stepTwo <= 1'b0;
    `CHK("jumpCnt", 7, upCnt + dnCnt)
    rdChk(3'h3, 8'h02, "irqStat");
    wr(3'h3, 8'h02);
    tick <= 1'b0;
    wr(3'h0, 8'h80);
    upCnt = 0;
    dnCnt = 0;
    step(1'b0);
    `CHK("quadOff", 0, upCnt + dnCnt)
  endtask
  task automatic t_flag;
    wr(3'h4, 8'h01);
    evt(1'b0, 1'b1, 1'b1);
    waitIrq(1'b1);
    rdChk(3'h3, 8'h01, "irqStat");
    wr(3'h3, 8'h01);
    waitIrq(1'b0);
    wr(3'h0, 8'he0);
    evt(1'b0, 1'b1, 1'b0);
    evt(1'b1, 1'b0, 1'b1);
    waitIrq(1'b1);
    wr(3'h4, 8'h00);
    waitIrq(1'b0);
  endtask
  task automatic t_standby;
    wr(3'h1, 8'h0a);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    @(posedge clk);
    rdChk(3'h0, 8'h80, "mode");
    rdChk(3'h1, 8'hc0, "func");
    rdChk(3'h2, 8'hff, "outEn");
    rdChk(3'h3, 8'h00, "irqStat");
    `CHK("bufferSel", 4'h0, bufferSel)
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_gate();
    t_pwm();
    t_quad();
    t_flag();
    t_standby();
    give_verdict();
  end
endmodule
